// >>> src/sbu_channel.v
// Serial bit unit channel: one-bit receive and transmit buffers with AXI4-Lite access
// Contract
// [RULE_01] A validated space on the idle line starts the receive sampling clock.
// [RULE_02] The start bit itself is loaded into the receive buffer; receive flag set.
// [RULE_03] While clock runs, each line sample loads the buffer and sets the flag.
// [RULE_04] Samples after the start bit are taken at each bit midpoint.
// [RULE_05] Space must last half a bit time to start the clock; shorter is noise.
// [RULE_06] Reading receive data returns the bit at position 18, clears buffer and flag; the code returns it at bit 17.
// [RULE_07] Program must remove the buffered bit before the next sample, else lost.
// [RULE_08] Clock reset function keeps clock stopped and flag clear until next start.
// [RULE_09] Transmit write copies data bit 0 to transmit buffer, clears transmit flag.
// [RULE_10] Function 1 clears receive, 2 clears transmit, 5 resets clock, 6-10 nothing.
// [RULE_11] Function 3 selects receive, carrier off; 4 selects transmit, carrier on.
// [RULE_12] Test 1 receive flag, 2 transmit flag, 5 interlock, 6 carrier; others zero.
// [RULE_13] Control via function drivers, flags via status lines, data via data ports.
// [RULE_14] Hardware scan interrogates channels and moves data, 1+3N word times.
// [RULE_15] Half-duplex: controller ignores the unused side and switches carrier.
// [RULE_16] The last character of a message is all marks so the line rests marking.
// [RULE_17] Transmit flag is set on every transmit bit tick.
// [RULE_18] Each transmit tick drives the buffered bit, repeating an old one.
`timescale 1ns/1ns
`default_nettype none
`include "sbu_consts.vh"
module sbu_channel (
	input wire CLK,
	input wire RST_B,
	input wire [11:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [11:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire LINE_RX,
	output reg LINE_TX,
	output reg CARRIER_ON,
	input wire CARRIER_DETECT,
	input wire INTERLOCK,
	output reg IRQ
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg rx_buf;
	reg rx_flag;
	reg rx_clk_run;
	reg tx_buf;
	reg tx_flag;
	reg tx_mode;
	reg [19:0] bit_period;
	reg [19:0] space_cnt;
	reg [3:0] last_test;
	reg test_result;
	reg [1:0] irq_stat;
	reg [1:0] irq_en;
	reg aw_held;
	reg w_held;
	reg [11:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire rx_tick;
	wire tx_tick;
	wire start_ok;
	wire wr_go;
	wire rd_go;
	wire wr_low;
	wire rx_take;
	wire tx_load;
	wire fn_go;
	wire [3:0] fn_code;
	wire rx_set;
	wire tx_set;

	// Report one status test code
	function test_sel;
		input [3:0] code;
		input rxf;
		input txf;
		input ilk;
		input car;
		begin
			case (code)
				`SBU_TS_RXFLAG: test_sel = rxf;
				`SBU_TS_TXFLAG: test_sel = txf;
				`SBU_TS_INTERLOCK: test_sel = ilk;
				`SBU_TS_CARRIER: test_sel = car;
				default: test_sel = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Bit timers
	// ----------------------------------------------------------------
	// Receive sampler re-armed at start so later ticks hit bit centres
	sbu_bit_timer u_rx_timer (
		.clk(CLK),
		.rst_b(RST_B),
		.period(bit_period),
		.restart(start_ok),
		.tick(rx_tick)
	);
	// Transmit timer runs free from the data timing unit
	sbu_bit_timer u_tx_timer (
		.clk(CLK),
		.rst_b(RST_B),
		.period(bit_period),
		.restart(1'b0),
		.tick(tx_tick)
	);

	// ----------------------------------------------------------------
	// AXI4-Lite decode
	// ----------------------------------------------------------------
	assign wr_go = aw_held && w_held && !S_AXI_BVALID;
	assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
	assign wr_low = w_strb[0];
	assign fn_go = wr_go && aw_addr == `SBU_OFF_CMD && wr_low; // RULE_13
	assign fn_code = w_data[3:0];
	assign tx_load = wr_go && aw_addr == `SBU_OFF_TXDATA && wr_low;
	assign rx_take = rd_go && S_AXI_ARADDR == `SBU_OFF_RXDATA;
	// Half-bit qualified space on the idle line
	assign start_ok = !rx_clk_run && !LINE_RX &&
		space_cnt == {1'b0, bit_period[19:1]}; // RULE_05
	assign rx_set = start_ok || (rx_clk_run && rx_tick);
	assign tx_set = tx_tick;

	// Address and data accepted in either order, held until response
	always @(posedge CLK) begin
		if (!RST_B) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `SBU_BRESP_OKAY;
		end else begin
			S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
			S_AXI_WREADY <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= {S_AXI_AWADDR[11:2], 2'b00};
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				case (aw_addr)
					`SBU_OFF_CMD, `SBU_OFF_TEST, `SBU_OFF_TXDATA,
					`SBU_OFF_IRQ_CLR, `SBU_OFF_IRQ_EN, `SBU_OFF_DIV:
						S_AXI_BRESP <= `SBU_BRESP_OKAY;
					default: S_AXI_BRESP <= `SBU_BRESP_SLVERR;
				endcase
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Read channel: one-cycle accept, data registered next cycle
	always @(posedge CLK) begin
		if (!RST_B) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `SBU_BRESP_OKAY;
		end else begin
			S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
			if (rd_go) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= `SBU_BRESP_OKAY;
				S_AXI_RDATA <= 32'h00000000;
				case ({2'b00, S_AXI_ARADDR[11:2]})
					`SBU_OFF_RXDATA >> 2:
						S_AXI_RDATA[`SBU_RXBIT_POS] <= rx_buf; // RULE_06
					`SBU_OFF_TXDATA >> 2: S_AXI_RDATA[0] <= tx_buf;
					`SBU_OFF_TEST >> 2: S_AXI_RDATA[3:0] <= last_test;
					`SBU_OFF_STAT >> 2:
						S_AXI_RDATA[6:0] <= {test_result, INTERLOCK, CARRIER_DETECT,
							tx_mode, rx_clk_run, tx_flag, rx_flag};
					`SBU_OFF_IRQ_STAT >> 2: S_AXI_RDATA[1:0] <= irq_stat;
					`SBU_OFF_IRQ_EN >> 2: S_AXI_RDATA[1:0] <= irq_en;
					`SBU_OFF_DIV >> 2: S_AXI_RDATA[19:0] <= bit_period;
					`SBU_OFF_CMD >> 2, `SBU_OFF_IRQ_CLR >> 2:
						S_AXI_RDATA <= 32'h00000000;
					default: S_AXI_RRESP <= `SBU_BRESP_SLVERR;
				endcase
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive section
	// ----------------------------------------------------------------
	// Space length counter; any mark resets it, so short pulses are dropped
	always @(posedge CLK) begin
		if (!RST_B || LINE_RX || rx_clk_run) begin
			space_cnt <= 20'h00000;
		end else if (space_cnt != {1'b0, bit_period[19:1]}) begin
			space_cnt <= space_cnt + 20'h00001; // RULE_05
		end
	end

	// Receive clock, buffer and flag; a new sample wins over a clear
	always @(posedge CLK) begin
		if (!RST_B) begin
			rx_clk_run <= 1'b0;
			rx_buf <= 1'b0;
			rx_flag <= 1'b0;
		end else begin
			if (fn_go && fn_code == `SBU_FN_RST_CLK) begin
				rx_clk_run <= 1'b0; // RULE_08
			end else if (start_ok) begin
				rx_clk_run <= 1'b1; // RULE_01
			end
			if (rx_take || (fn_go && fn_code == `SBU_FN_CLR_RX)) begin
				rx_buf <= 1'b0; // RULE_06 RULE_10
				rx_flag <= 1'b0;
			end
			if (rx_set && !(fn_go && fn_code == `SBU_FN_RST_CLK)) begin
				// Start bit or mid-bit sample; overwrites an untaken bit
				rx_buf <= LINE_RX; // RULE_02 RULE_03 RULE_04 RULE_07
				rx_flag <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit section
	// ----------------------------------------------------------------
	// Line always rests marking after reset; tick repeats the held bit
	always @(posedge CLK) begin
		if (!RST_B) begin
			tx_buf <= 1'b1;
			tx_flag <= 1'b0;
			LINE_TX <= 1'b1;
		end else begin
			if (tx_load) begin
				tx_buf <= w_data[0]; // RULE_09
				tx_flag <= 1'b0;
			end else if (fn_go && fn_code == `SBU_FN_CLR_TX) begin
				tx_buf <= 1'b1; // RULE_10
				tx_flag <= 1'b0;
			end
			if (tx_set) begin
				tx_flag <= 1'b1; // RULE_17
				LINE_TX <= tx_buf; // RULE_18 RULE_16
			end
		end
	end

	// Mode and carrier; codes 6 to 10 fall through to no action
	always @(posedge CLK) begin
		if (!RST_B) begin
			tx_mode <= 1'b0;
			CARRIER_ON <= 1'b0;
		end else if (fn_go && fn_code == `SBU_FN_RX_MODE) begin
			tx_mode <= 1'b0; // RULE_11 RULE_15
			CARRIER_ON <= 1'b0;
		end else if (fn_go && fn_code == `SBU_FN_TX_MODE) begin
			tx_mode <= 1'b1; // RULE_11
			CARRIER_ON <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Status tests, timing and interrupts
	// ----------------------------------------------------------------
	// Test register selects a status line, result tracks it live
	always @(posedge CLK) begin
		if (!RST_B) begin
			last_test <= 4'h0;
			test_result <= 1'b0;
			bit_period <= `SBU_DIV_RESET;
			irq_en <= 2'b00;
		end else begin
			if (wr_go && aw_addr == `SBU_OFF_TEST && wr_low) begin
				last_test <= w_data[3:0];
			end
			if (wr_go && aw_addr == `SBU_OFF_DIV && w_data[19:1] != 19'h00000) begin
				bit_period <= w_data[19:0];
			end
			if (wr_go && aw_addr == `SBU_OFF_IRQ_EN && wr_low) begin
				irq_en <= w_data[1:0];
			end
			test_result <= test_sel(last_test, rx_flag, tx_flag,
				INTERLOCK, CARRIER_DETECT); // RULE_12 RULE_14
		end
	end

	// Sticky events, write-one clear, set wins
	always @(posedge CLK) begin
		if (!RST_B) begin
			irq_stat <= 2'b00;
			IRQ <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~((wr_go && aw_addr == `SBU_OFF_IRQ_CLR) ?
				w_data[1:0] : 2'b00)) | {tx_set, rx_set};
			IRQ <= |(irq_stat & irq_en);
		end
	end
endmodule // sbu_channel
`default_nettype wire

// >>> src/sbu_consts.vh
// Constants of the serial bit unit: register map, fields, codes and timing
`ifndef SBU_CONSTS_VH
`define SBU_CONSTS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SBU_OFF_CMD 12'h000
`define SBU_OFF_TEST 12'h004
`define SBU_OFF_RXDATA 12'h008
`define SBU_OFF_TXDATA 12'h00c
`define SBU_OFF_STAT 12'h010
`define SBU_OFF_IRQ_STAT 12'h014
`define SBU_OFF_IRQ_CLR 12'h018
`define SBU_OFF_IRQ_EN 12'h01c
`define SBU_OFF_DIV 12'h020
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SBU_RXBIT_POS 17
`define SBU_ST_RXFLAG 0
`define SBU_ST_TXFLAG 1
`define SBU_ST_RXCLK 2
`define SBU_ST_TXMODE 3
`define SBU_ST_CARRIER 4
`define SBU_ST_INTERLOCK 5
`define SBU_ST_TESTRES 6
`define SBU_IRQ_RX 0
`define SBU_IRQ_TX 1
// ----------------------------------------------------------------
// Function and test codes
// ----------------------------------------------------------------
`define SBU_FN_CLR_RX 4'h1
`define SBU_FN_CLR_TX 4'h2
`define SBU_FN_RX_MODE 4'h3
`define SBU_FN_TX_MODE 4'h4
`define SBU_FN_RST_CLK 4'h5
`define SBU_TS_RXFLAG 4'h1
`define SBU_TS_TXFLAG 4'h2
`define SBU_TS_INTERLOCK 4'h5
`define SBU_TS_CARRIER 4'h6
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define SBU_DIV_RESET 20'h61a80
`define SBU_SCAN_SETUP_WT 3'h1
`define SBU_SCAN_CHAN_WT 3'h3
`define SBU_BRESP_OKAY 2'h0
`define SBU_BRESP_SLVERR 2'h2
`endif

// >>> src/sbu_bit_timer.v
// Bit period timer: free tick every period, or sampler re-armed at a start bit
`timescale 1ns/1ns
`default_nettype none
module sbu_bit_timer (
	input wire clk,
	input wire rst_b,
	input wire [19:0] period,
	input wire restart,
	output reg tick
);
	reg [19:0] count;
	// Count down one bit period; restart comes half a bit into the start bit,
	// so a full period puts each later tick near a bit centre. Reset loads
	// all ones so no tick follows reset; a shortened period pulls count in.
	always @(posedge clk) begin
		if (!rst_b) begin
			count <= 20'hfffff;
			tick <= 1'b0;
		end else if (restart) begin
			count <= period;
			tick <= 1'b0;
		end else if (count > period) begin
			count <= period;
			tick <= 1'b0;
		end else if (count <= 20'h00001) begin
			count <= period;
			tick <= 1'b1;
		end else begin
			count <= count - 20'h00001;
			tick <= 1'b0;
		end
	end
endmodule // sbu_bit_timer
`default_nettype wire

// >>> test/sbu_channel_props.sv
// Port assertions for the serial bit unit channel
`timescale 1ns/1ns
`default_nettype none
`include "sbu_consts.vh"
module sbu_channel_props (
	input wire CLK,
	input wire RST_B,
	input wire S_AXI_AWVALID,
	input wire S_AXI_AWREADY,
	input wire S_AXI_WVALID,
	input wire S_AXI_WREADY,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [11:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire [1:0] S_AXI_RRESP,
	input wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire LINE_TX,
	input wire CARRIER_ON,
	input wire IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// ----------------------
	// Assertions
	// ----------------------
	chk_reset_idle: assert property ($rose(RST_B) |-> LINE_TX && !CARRIER_ON && !IRQ)
		else $error("Outputs not idle after reset");
	chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("Write response late");
	chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("Write response dropped");
	chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("Read data late");
	chk_unmapped_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
		S_AXI_ARADDR > (`SBU_OFF_DIV | 12'h003) |=>
		S_AXI_RRESP == `SBU_BRESP_SLVERR && S_AXI_RDATA == 32'h0)
		else $error("Unmapped read not refused");
	chk_rx_position: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
		S_AXI_ARADDR == `SBU_OFF_RXDATA |=> (S_AXI_RDATA & ~(32'h1 << `SBU_RXBIT_POS)) == 32'h0)
		else $error("Received bit outside its position");
	chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("Read data not held");
	chk_carrier_cmd: assert property ($changed(CARRIER_ON) |-> ##[0:1] S_AXI_BVALID)
		else $error("Carrier moved without a command");
	// Main scenarios reached
	cover property (S_AXI_RVALID && S_AXI_RRESP == `SBU_BRESP_SLVERR);
	cover property ($rose(CARRIER_ON));
	cover property ($rose(IRQ));
endmodule // sbu_channel_props
bind sbu_channel sbu_channel_props u_sbu_channel_props (.*);
`default_nettype wire

// >>> test/sbu_tty.sv
// Remote terminal model driving the receive line
`timescale 1ns/1ns
`default_nettype none
module sbu_tty (
	input wire logic clk,
	output logic line
);
	// Idle line rests marking
	initial line = 1'h1;
	// Short space burst, shorter than half a bit
	task glitch(input int n);
		line <= 1'h0;
		repeat (n) @(posedge clk);
		line <= 1'h1;
	endtask
	// Start space, five data bits, two stop marks
	task send(input logic [4:0] b, input int cpb);
		logic [7:0] fr;
		fr = {2'h3, b, 1'h0};
		for (int i = 0; i < 8; i++) begin
			line <= fr[i];
			repeat (cpb) @(posedge clk);
		end
	endtask
endmodule // sbu_tty
`default_nettype wire

// >>> test/serial_bit_buffer_channel_tb_top.sv
// Self-checking bench for the serial bit unit channel
`timescale 1ns/1ns
`default_nettype none
`include "sbu_consts.vh"
module serial_bit_buffer_channel_tb_top;
	logic CLK, RST_B, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
	logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, LINE_RX;
	logic LINE_TX, CARRIER_ON, CARRIER_DETECT, INTERLOCK, IRQ;
	logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [33:0] exp_q[$], msk_q[$], m;
	logic [5:0] fr;
	int error_cnt = 0, comparisons = 0;
	sbu_channel u_sbu_channel (.*);
	sbu_tty u_sbu_tty (.clk(CLK), .line(LINE_RX));
	// Clock and watchdog
	initial begin
		CLK = 1'h0;
		forever #25 CLK = ~CLK;
	end
	initial begin
		repeat (5000) @(posedge CLK);
		error_cnt++;
		finish_test;
	end
	// ----------------------
	// Checking and bus tasks
	// ----------------------
	task check(input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("Checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		bit pa, pw;
		pa = 1;
		pw = 1;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_BREADY <= 1'h1;
		while (pa || pw) begin
			S_AXI_AWVALID <= pa;
			S_AXI_WVALID <= pw;
			@(posedge CLK);
			pa = pa && !S_AXI_AWREADY;
			pw = pw && !S_AXI_WREADY;
		end
		S_AXI_AWVALID <= 1'h0;
		S_AXI_WVALID <= 1'h0;
		do @(posedge CLK); while (!S_AXI_BVALID);
		S_AXI_BREADY <= 1'h0;
		@(posedge CLK);
	endtask
	task rd(input logic [11:0] a, input logic [33:0] e, input logic [33:0] mk);
		exp_q.push_back(e & mk);
		msk_q.push_back(mk);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do @(posedge CLK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'h0;
		do @(posedge CLK); while (!S_AXI_RVALID);
		S_AXI_RREADY <= 1'h0;
		@(posedge CLK);
	endtask
	// Read monitor compares against the oldest note
	always @(posedge CLK) begin
		if (S_AXI_RVALID && S_AXI_RREADY) begin
			m = msk_q.pop_front();
			check({S_AXI_RRESP, S_AXI_RDATA} & m, exp_q.pop_front());
		end
	end
	// ----------------------
	// Main sequence
	// ----------------------
	initial begin
		{RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = {56'h0, 4'hf};
		void'($urandom(32'h908d7f72));
		{INTERLOCK, CARRIER_DETECT} = 2'($urandom);
		fr = {5'($urandom), 1'h0};
		repeat (8) @(posedge CLK);
		RST_B <= 1'h1;
		@(posedge CLK);
		check(34'({LINE_TX, CARRIER_ON, IRQ}), 34'h4);
		rd(`SBU_OFF_STAT, 34'({INTERLOCK, CARRIER_DETECT}) << 4, 34'h3f);
		// Function and test codes 1 to 10
		for (int c = 1; c <= 10; c++) begin
			wr(`SBU_OFF_CMD, 32'(c));
			check(34'(CARRIER_ON), 34'(c >= 4));
			rd(`SBU_OFF_STAT, 34'({INTERLOCK, CARRIER_DETECT, c >= 4}) << 3, 34'h38);
			wr(`SBU_OFF_TEST, 32'(c));
			rd(`SBU_OFF_STAT, 34'(c == 5 ? INTERLOCK : c == 6 && CARRIER_DETECT) << 6, 34'h40);
		end
		rd(12'h024, {`SBU_BRESP_SLVERR, 32'h0}, {34{1'h1}});
		// Transmit ticks with a short bit period
		wr(`SBU_OFF_DIV, 32'h14);
		wr(`SBU_OFF_TXDATA, 32'h0);
		for (int i = 0; i < 60 && LINE_TX !== 1'h0; i++) @(posedge CLK);
		check(34'(LINE_TX), 34'h0);
		wr(`SBU_OFF_TXDATA, 32'h3);
		rd(`SBU_OFF_STAT, 34'h0, 34'h2);
		for (int i = 0; i < 40 && LINE_TX !== 1'h1; i++) @(posedge CLK);
		check(34'(LINE_TX), 34'h1);
		rd(`SBU_OFF_STAT, 34'h2, 34'h2);
		check(34'(IRQ), 34'h0);
		// Noise, then one frame sampled bit by bit
		wr(`SBU_OFF_IRQ_EN, 32'h1);
		u_sbu_tty.glitch(5);
		repeat (30) @(posedge CLK);
		rd(`SBU_OFF_STAT, 34'h0, 34'h5);
		fork
			u_sbu_tty.send(fr[5:1], 20);
		join_none
		for (int k = 0; k < 6; k++) begin
			for (int i = 0; i < 40 && IRQ !== 1'h1; i++) @(posedge CLK);
			check(34'(IRQ), 34'h1);
			wr(`SBU_OFF_IRQ_CLR, 32'h1);
			rd(`SBU_OFF_RXDATA, 34'(fr[k]) << 17, {34{1'h1}});
			if (k == 0) rd(`SBU_OFF_STAT, 34'h4, 34'h4);
		end
		wr(`SBU_OFF_CMD, 32'(`SBU_FN_RST_CLK));
		repeat (60) @(posedge CLK);
		rd(`SBU_OFF_STAT, 34'h0, 34'h5);
		finish_test;
	end
endmodule // serial_bit_buffer_channel_tb_top
`default_nettype wire
